// ---- rtl/servo_input_pkg.sv ----
package servo_input_pkg;

	// ==========================================================
	// register map (word addresses, one per register)
	localparam logic [3:0] ADDR_CONTROL    = 4'h0;
	localparam logic [3:0] ADDR_POLARITY   = 4'h1;
	localparam logic [3:0] ADDR_PULSE_MODE = 4'h2;
	localparam logic [3:0] ADDR_SPEED_LIM  = 4'h3;
	localparam logic [3:0] ADDR_CUR_FWD    = 4'h4;
	localparam logic [3:0] ADDR_CUR_REV    = 4'h5;
	localparam logic [3:0] ADDR_STATUS     = 4'h6;
	localparam logic [3:0] ADDR_DEVIATION  = 4'h7;
	localparam logic [3:0] ADDR_CMD_COUNT  = 4'h8;
	localparam logic [3:0] ADDR_FB_COUNT   = 4'h9;
	localparam logic [3:0] ADDR_OVF_LIMIT  = 4'ha;

	// ==========================================================
	// discrete input bit positions in the polarity register
	localparam int IN_SERVO_ON   = 0;
	localparam int IN_FWD_INH    = 1;
	localparam int IN_REV_INH    = 2;
	localparam int IN_COMB_CLR   = 3;
	localparam int IN_ALARM_CLR  = 4;
	localparam int IN_DEVIATION_CLEAR_IN    = 5;
	localparam int IN_SPEED_LIM  = 6;
	localparam int IN_CUR_LIM    = 7;
	localparam int NUM_INPUTS    = 8;

	// control register bits
	localparam int CTL_FATAL_ALARM = 0;
	localparam int CTL_CUR_STALL   = 1;
	localparam int CTL_FB_STEP     = 2;
	localparam int CTL_FB_DIR      = 3;

	// ==========================================================
	// reset values
	localparam logic [7:0]  POLARITY_RESET  = 8'h00;
	localparam logic [1:0]  PULSE_MODE_RST  = 2'h0;
	localparam logic [15:0] SPEED_LIM_RESET = 16'h0100;
	localparam logic [15:0] CUR_LIM_RESET   = 16'h0100;
	localparam logic [31:0] OVF_LIM_RESET   = 32'h0000_ffff;

	typedef enum logic [1:0] {
		FMT_TWO_PULSE,
		FMT_ONE_PULSE,
		FMT_TWO_PHASE
	} pulse_fmt_type;

	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} encoder_type;

	typedef struct packed {
		logic servo_power;
		logic fwd_allowed;
		logic rev_allowed;
		logic speed_limited;
		logic current_limited;
		logic alarm;
		logic fatal;
	} drive_state_type;

	// ==========================================================
	// timing
	localparam int CLK_MHZ       = 200;
	localparam int DEBOUNCE_US   = 1;
	localparam int DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;

endpackage

// ---- rtl/servo_position_input_control.sv ----
`timescale 1ns/10ps

// Summary of operation
// - servo enable input energises servo power
// - open forward inhibit blocks forward motion
// - open reverse inhibit blocks reverse motion
// - both inhibits open block all motion
// - inhibit closed lifts block, polarity invertible
// - clear with alarm: release alarm, zero deviation
// - clear without alarm: zero counts, align command
// - combined clear acts on rising edge
// - fatal alarms survive every clear input
// - overflow alarm needs deviation clear before alarm clear
// - alarm clear acts on rising edge
// - deviation clear zeroes deviation, aligns command
// - deviation clear acts on rising edge
// - speed limit input caps commanded speed
// - deviation beyond overflow limit raises overflow
// - current limit input caps forward/reverse current
// - pulses during current stall raise overflow
// - decode two-pulse, one-pulse or quadrature commands
// - pulses ignored while servo power off
// - encoder A, B, Z forwarded differentially
// - every discrete input polarity invertible after debounce
module servo_position_input_control #(
	parameter int CNT_W = 32
) (
	input  wire logic                              CLK,
	input  wire logic                              ARST_N,
	input  wire logic [3:0]                        AVS_ADDRESS,
	input  wire logic                              AVS_READ,
	input  wire logic                              AVS_WRITE,
	input  wire logic [31:0]                       AVS_WRITEDATA,
	input  wire logic [3:0]                        AVS_BYTEENABLE,
	output logic [31:0]                            AVS_READDATA,
	output logic                                   AVS_WAITREQUEST,
	input  wire logic                              SERVO_ENABLE_IN,
	input  wire logic                              FORWARD_INHIBIT_IN,
	input  wire logic                              REVERSE_INHIBIT_IN,
	input  wire logic                              COMBINED_CLEAR_IN,
	input  wire logic                              ALARM_CLEAR_IN,
	input  wire logic                              DEVIATION_CLEAR_IN,
	input  wire logic                              SPEED_LIMIT_IN,
	input  wire logic                              CURRENT_LIMIT_IN,
	input  wire logic                              FORWARD_PULSE_P,
	input  wire logic                              FORWARD_PULSE_N,
	input  wire logic                              REVERSE_PULSE_P,
	input  wire logic                              REVERSE_PULSE_N,
	input  wire servo_input_pkg::encoder_type      ENCODER_IN,
	output servo_input_pkg::encoder_type           ENCODER_MON_P,
	output servo_input_pkg::encoder_type           ENCODER_MON_N,
	output servo_input_pkg::drive_state_type       DRIVE_STATE,
	output logic [15:0]                            SPEED_CAP,
	output logic [15:0]                            CURRENT_CAP_FWD,
	output logic [15:0]                            CURRENT_CAP_REV
);

	if (CNT_W < 8 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must lie in 8..32");
	end

	// ==========================================================
	// reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) rst_sync_q <= 2'h0;
		else rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// ==========================================================
	// registers
	logic [7:0]       polarity_q;
	logic [1:0]       pulse_mode_q;
	logic [15:0]      speed_lim_q;
	logic [15:0]      cur_fwd_q;
	logic [15:0]      cur_rev_q;
	logic [3:0]       control_q;
	logic [31:0]      ovf_limit_q;
	logic             bus_ack_q;
	logic [31:0]      rdata_q;

	logic signed [CNT_W-1:0] deviation_q;
	logic signed [CNT_W-1:0] cmd_count_q;
	logic signed [CNT_W-1:0] fb_count_q;
	logic             alarm_q;
	logic             fatal_q;
	logic             dev_cleared_q;

	// ==========================================================
	// discrete inputs: three-stage sync, stable debounce
	// sync and debounce
	localparam int NUM_W = servo_input_pkg::NUM_INPUTS;
	logic [NUM_W-1:0] raw_in;
	logic [NUM_W-1:0] s1_q, s2_q, s3_q;
	logic [NUM_W-1:0] stable_q;
	logic [NUM_W-1:0] stable_prev_q;
	logic [7:0]       deb_cnt_q [NUM_W];
	logic [NUM_W-1:0] active;
	logic [NUM_W-1:0] rise;

	assign raw_in = {CURRENT_LIMIT_IN, SPEED_LIMIT_IN, DEVIATION_CLEAR_IN, ALARM_CLEAR_IN,
		COMBINED_CLEAR_IN, REVERSE_INHIBIT_IN, FORWARD_INHIBIT_IN, SERVO_ENABLE_IN};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar i = 0; i < NUM_W; i++) begin : g_deb
		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				deb_cnt_q[i] <= 8'h00;
				stable_q[i] <= 1'b0;
			end else if (s2_q[i] != s3_q[i] || s3_q[i] == stable_q[i]) begin
				deb_cnt_q[i] <= 8'h00;
			end else if (deb_cnt_q[i] == 8'(servo_input_pkg::DEBOUNCE_CYC - 1)) begin
				deb_cnt_q[i] <= 8'h00;
				stable_q[i] <= s3_q[i];
			end else begin
				deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
			end
		end
	end

	wire [NUM_W-1:0] logical_in = stable_q ^ polarity_q;
	logic [NUM_W-1:0] logical_prev;
	assign logical_prev = stable_prev_q ^ polarity_q;
	assign active = logical_in;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) stable_prev_q <= '0;
		else stable_prev_q <= stable_q;
	end
	assign rise = logical_in & ~logical_prev;

	wire comb_clr_evt = rise[servo_input_pkg::IN_COMB_CLR];
	wire alarm_clear_in_evt  = rise[servo_input_pkg::IN_ALARM_CLR];
	wire deviation_clear_in_evt  = rise[servo_input_pkg::IN_DEVIATION_CLEAR_IN];

	// ==========================================================
	// motion permissions
	// servo power follows enable, alarm removes it
	wire servo_on = active[servo_input_pkg::IN_SERVO_ON] & ~alarm_q & ~fatal_q;
	wire fwd_ok   = servo_on & active[servo_input_pkg::IN_FWD_INH];
	wire rev_ok   = servo_on & active[servo_input_pkg::IN_REV_INH];
	wire spd_lim  = active[servo_input_pkg::IN_SPEED_LIM];
	wire cur_lim  = active[servo_input_pkg::IN_CUR_LIM];

	// ==========================================================
	// command pulse decode (pins are active low)
	// negative logic from host
	logic [2:0] pa_q, pb_q;
	logic       a_prev_q, b_prev_q;
	wire        cmd_a = ~(FORWARD_PULSE_P & ~FORWARD_PULSE_N);
	wire        cmd_b = ~(REVERSE_PULSE_P & ~REVERSE_PULSE_N);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pa_q <= 3'h0;
			pb_q <= 3'h0;
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
		end else begin
			pa_q <= {pa_q[1:0], cmd_a};
			pb_q <= {pb_q[1:0], cmd_b};
			if (pa_q[1] == pa_q[2]) a_prev_q <= pa_q[2];
			if (pb_q[1] == pb_q[2]) b_prev_q <= pb_q[2];
		end
	end
	wire a_now = (pa_q[1] == pa_q[2]) ? pa_q[2] : a_prev_q;
	wire b_now = (pb_q[1] == pb_q[2]) ? pb_q[2] : b_prev_q;
	wire a_rise = a_now & ~a_prev_q;
	wire a_chg  = a_now ^ a_prev_q;
	wire b_rise = b_now & ~b_prev_q;
	wire b_chg  = b_now ^ b_prev_q;

	// idle channel held inactive by host
	logic step_fwd, step_rev;
	always_comb begin
		step_fwd = 1'b0;
		step_rev = 1'b0;
		case (servo_input_pkg::pulse_fmt_type'(pulse_mode_q))
			servo_input_pkg::FMT_TWO_PULSE: begin
				step_fwd = a_rise;
				step_rev = b_rise;
			end
			servo_input_pkg::FMT_ONE_PULSE: begin
				step_fwd = a_rise & ~b_now;
				step_rev = a_rise & b_now;
			end
			servo_input_pkg::FMT_TWO_PHASE: begin
				step_fwd = (a_chg & (a_now ^ b_now)) | (b_chg & ~(a_now ^ b_now));
				step_rev = (a_chg & ~(a_now ^ b_now)) | (b_chg & (a_now ^ b_now));
			end
			default: begin
				step_fwd = 1'b0;
				step_rev = 1'b0;
			end
		endcase
	end

	wire take_fwd = step_fwd & servo_on & ~step_rev;
	wire take_rev = step_rev & servo_on & ~step_fwd;

	// ==========================================================
	// feedback step from the loop, gated by direction
	wire fb_step = control_q[servo_input_pkg::CTL_FB_STEP];
	wire fb_dir  = control_q[servo_input_pkg::CTL_FB_DIR];
	wire fb_fwd  = fb_step & ~fb_dir & fwd_ok;
	wire fb_rev  = fb_step & fb_dir & rev_ok;

	wire [CNT_W-1:0] dev_abs = deviation_q[CNT_W-1] ? CNT_W'(-deviation_q) : CNT_W'(deviation_q);
	wire overflow = (dev_abs > CNT_W'(ovf_limit_q)) |
		(control_q[servo_input_pkg::CTL_CUR_STALL] & cur_lim & (take_fwd | take_rev) & (dev_abs != '0));

	// ==========================================================
	// counters and alarms
	wire any_clear = comb_clr_evt | deviation_clear_in_evt | (comb_clr_evt & alarm_q);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			cmd_count_q <= '0;
			fb_count_q  <= '0;
			deviation_q <= '0;
		end else if (comb_clr_evt & ~alarm_q & ~fatal_q) begin
			cmd_count_q <= '0;
			fb_count_q  <= '0;
			deviation_q <= '0;
		end else if (any_clear) begin
			cmd_count_q <= fb_count_q;
			deviation_q <= '0;
		end else begin
			cmd_count_q <= cmd_count_q + CNT_W'(take_fwd) - CNT_W'(take_rev);
			fb_count_q  <= fb_count_q + CNT_W'(fb_fwd) - CNT_W'(fb_rev);
			deviation_q <= deviation_q + CNT_W'(take_fwd) - CNT_W'(take_rev)
				- CNT_W'(fb_fwd) + CNT_W'(fb_rev);
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			alarm_q <= 1'b0;
			fatal_q <= 1'b0;
			dev_cleared_q <= 1'b0;
		end else begin
			// fatal alarm latched until power cycle
			if (control_q[servo_input_pkg::CTL_FATAL_ALARM]) fatal_q <= 1'b1;
			if (deviation_clear_in_evt) dev_cleared_q <= 1'b1;
			else if (alarm_clear_in_evt) dev_cleared_q <= 1'b0;
			// alarm clear needs prior deviation clear
			// a clear zeroes the deviation, so its stale overflow must not re-arm
			if (overflow & ~any_clear) alarm_q <= 1'b1;
			else if (comb_clr_evt | (alarm_clear_in_evt & (dev_cleared_q | deviation_clear_in_evt))) alarm_q <= 1'b0;
		end
	end

	// ==========================================================
	// outputs
	// limit caps reported to the loop
	assign SPEED_CAP       = spd_lim ? speed_lim_q : 16'hffff;
	assign CURRENT_CAP_FWD = cur_lim ? cur_fwd_q : 16'hffff;
	assign CURRENT_CAP_REV = cur_lim ? cur_rev_q : 16'hffff;
	assign DRIVE_STATE = '{servo_power: servo_on, fwd_allowed: fwd_ok, rev_allowed: rev_ok,
		speed_limited: spd_lim, current_limited: cur_lim, alarm: alarm_q, fatal: fatal_q};

	logic [8:0]                   enc_sync_q;
	servo_input_pkg::encoder_type enc_q;
	wire  [2:0]                   enc_s2 = enc_sync_q[5:3];
	wire  [2:0]                   enc_s3 = enc_sync_q[8:6];
	// three-stage sync, a bit follows once stages two and three agree
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			enc_sync_q <= 9'h000;
			enc_q <= '0;
		end else begin
			enc_sync_q <= {enc_sync_q[5:0], ENCODER_IN};
			enc_q <= (enc_s2 & enc_s3) | (enc_q & (enc_s2 ^ enc_s3));
		end
	end
	assign ENCODER_MON_P = enc_q;
	assign ENCODER_MON_N = ~enc_q;

	// ==========================================================
	// avalon slave: one wait cycle, answer on the second edge
	wire req    = AVS_READ | AVS_WRITE;
	wire wr_hit = AVS_WRITE & bus_ack_q;
	assign AVS_WAITREQUEST = req & ~bus_ack_q;
	assign AVS_READDATA    = rdata_q;

	logic [31:0] rd_mux;
	always_comb begin
		case (AVS_ADDRESS)
			servo_input_pkg::ADDR_CONTROL:    rd_mux = {28'h0, control_q};
			servo_input_pkg::ADDR_POLARITY:   rd_mux = {24'h0, polarity_q};
			servo_input_pkg::ADDR_PULSE_MODE: rd_mux = {30'h0, pulse_mode_q};
			servo_input_pkg::ADDR_SPEED_LIM:  rd_mux = {16'h0, speed_lim_q};
			servo_input_pkg::ADDR_CUR_FWD:    rd_mux = {16'h0, cur_fwd_q};
			servo_input_pkg::ADDR_CUR_REV:    rd_mux = {16'h0, cur_rev_q};
			servo_input_pkg::ADDR_STATUS:     rd_mux = {25'h0, DRIVE_STATE};
			servo_input_pkg::ADDR_DEVIATION:  rd_mux = 32'(deviation_q);
			servo_input_pkg::ADDR_CMD_COUNT:  rd_mux = 32'(cmd_count_q);
			servo_input_pkg::ADDR_FB_COUNT:   rd_mux = 32'(fb_count_q);
			servo_input_pkg::ADDR_OVF_LIMIT:  rd_mux = ovf_limit_q;
			default:                          rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			bus_ack_q <= req & ~bus_ack_q;
			if (AVS_READ & ~bus_ack_q) rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			polarity_q   <= servo_input_pkg::POLARITY_RESET;
			pulse_mode_q <= servo_input_pkg::PULSE_MODE_RST;
			speed_lim_q  <= servo_input_pkg::SPEED_LIM_RESET;
			cur_fwd_q    <= servo_input_pkg::CUR_LIM_RESET;
			cur_rev_q    <= servo_input_pkg::CUR_LIM_RESET;
			control_q    <= 4'h0;
			ovf_limit_q  <= servo_input_pkg::OVF_LIM_RESET;
		end else begin
			// feedback step is a one-cycle strobe
			control_q[servo_input_pkg::CTL_FB_STEP] <= 1'b0;
			if (wr_hit && AVS_BYTEENABLE[0]) begin
				case (AVS_ADDRESS)
					servo_input_pkg::ADDR_CONTROL:    control_q <= AVS_WRITEDATA[3:0];
					servo_input_pkg::ADDR_POLARITY:   polarity_q <= AVS_WRITEDATA[7:0];
					servo_input_pkg::ADDR_PULSE_MODE: pulse_mode_q <= AVS_WRITEDATA[1:0];
					servo_input_pkg::ADDR_SPEED_LIM:  speed_lim_q <= AVS_WRITEDATA[15:0];
					servo_input_pkg::ADDR_CUR_FWD:    cur_fwd_q <= AVS_WRITEDATA[15:0];
					servo_input_pkg::ADDR_CUR_REV:    cur_rev_q <= AVS_WRITEDATA[15:0];
					servo_input_pkg::ADDR_OVF_LIMIT:  ovf_limit_q <= AVS_WRITEDATA;
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// checks
	chk_pulse_gate_off: assert property (@(posedge CLK) disable iff (!rst_n)
		!servo_on |=> $stable(cmd_count_q) || $past(any_clear)) else $error("count moved with power off");
	chk_fwd_block: assert property (@(posedge CLK) disable iff (!rst_n)
		!active[servo_input_pkg::IN_FWD_INH] |-> !fwd_ok) else $error("forward allowed while inhibited");
	chk_rev_block: assert property (@(posedge CLK) disable iff (!rst_n)
		!active[servo_input_pkg::IN_REV_INH] |-> !rev_ok) else $error("reverse allowed while inhibited");
	chk_both_block: assert property (@(posedge CLK) disable iff (!rst_n)
		!active[2] && !active[1] |-> !fwd_ok && !rev_ok) else $error("motion with both inhibits open");
	chk_servo_follow: assert property (@(posedge CLK) disable iff (!rst_n)
		servo_on |-> active[servo_input_pkg::IN_SERVO_ON]) else $error("servo on without enable");
	chk_dev_zero: assert property (@(posedge CLK) disable iff (!rst_n)
		deviation_clear_in_evt |=> deviation_q == '0 && cmd_count_q == $past(fb_count_q)) else $error("deviation not cleared");
	chk_fatal_hold: assert property (@(posedge CLK) disable iff (!rst_n)
		fatal_q |=> fatal_q) else $error("fatal alarm released");
	chk_comb_alarm: assert property (@(posedge CLK) disable iff (!rst_n)
		comb_clr_evt |=> !alarm_q) else $error("combined clear left alarm");
	chk_edge_once: assert property (@(posedge CLK) disable iff (!rst_n)
		comb_clr_evt |=> !comb_clr_evt) else $error("clear edge repeated");
	chk_overflow_set: assert property (@(posedge CLK) disable iff (!rst_n)
		overflow && !any_clear |=> alarm_q) else $error("overflow without alarm");
	cov_alarm_clear: cover property (@(posedge CLK) disable iff (!rst_n) alarm_q ##1 !alarm_q);
	cov_fwd_step: cover property (@(posedge CLK) disable iff (!rst_n) take_fwd);
	cov_rev_step: cover property (@(posedge CLK) disable iff (!rst_n) take_rev);
	cov_dev_clear: cover property (@(posedge CLK) disable iff (!rst_n) deviation_clear_in_evt ##[1:1000] alarm_clear_in_evt);

endmodule

// ---- test/host_cmd_model.sv ----
`timescale 1ns/10ps

module host_cmd_model (
	input  wire logic clk,
	output logic      fwd_p,
	output logic      fwd_n,
	output logic      rev_p,
	output logic      rev_n
);
	logic a_act = 1'b0;
	logic b_act = 1'b0;

	// ==========================================================
	// active level is the low voltage
	assign fwd_p = ~a_act;
	assign fwd_n = a_act;
	assign rev_p = ~b_act;
	assign rev_n = b_act;

	// each level held four cycles
	task automatic hold(input logic a, input logic b);
		@(posedge clk);
		a_act <= a;
		b_act <= b;
		repeat (3) @(posedge clk);
	endtask

	task automatic send(input logic [1:0] fmt, input logic dir, input int n);
		for (int i = 0; i < n; i++) begin
			case (fmt)
				2'h0: begin
					hold(~dir, dir);
					hold(1'b0, 1'b0);
				end
				2'h1: begin
					hold(1'b0, dir);
					hold(1'b1, dir);
					hold(1'b0, dir);
				end
				default: begin
					hold(~dir, dir);
					hold(1'b1, 1'b1);
					hold(dir, ~dir);
					hold(1'b0, 1'b0);
				end
			endcase
		end
		hold(1'b0, 1'b0);
		repeat (8) @(posedge clk);
	endtask
endmodule

// ---- test/tb_servo_position_input_control.sv ----
`timescale 1ns/10ps

module tb_servo_position_input_control;
	logic                             clk;
	logic                             arst_n;
	logic [3:0]                       address;
	logic                             read;
	logic                             write;
	logic [31:0]                      writedata;
	logic [31:0]                      readdata;
	logic                             waitrequest;
	logic [7:0]                       pins;
	logic                             fwd_p;
	logic                             fwd_n;
	logic                             rev_p;
	logic                             rev_n;
	logic [15:0]                      spd_cap;
	logic [15:0]                      cur_fwd;
	logic [15:0]                      cur_rev;
	logic [31:0]                      rd;
	servo_input_pkg::encoder_type     enc;
	servo_input_pkg::encoder_type     mon_p;
	servo_input_pkg::encoder_type     mon_n;
	servo_input_pkg::drive_state_type st;
	int                               n_fail = 0;
	int                               num_checks = 0;

	servo_position_input_control dut_u (
		.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
		.AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(readdata),
		.AVS_WAITREQUEST(waitrequest), .SERVO_ENABLE_IN(pins[0]), .FORWARD_INHIBIT_IN(pins[1]),
		.REVERSE_INHIBIT_IN(pins[2]), .COMBINED_CLEAR_IN(pins[3]), .ALARM_CLEAR_IN(pins[4]),
		.DEVIATION_CLEAR_IN(pins[5]), .SPEED_LIMIT_IN(pins[6]), .CURRENT_LIMIT_IN(pins[7]),
		.FORWARD_PULSE_P(fwd_p), .FORWARD_PULSE_N(fwd_n), .REVERSE_PULSE_P(rev_p),
		.REVERSE_PULSE_N(rev_n), .ENCODER_IN(enc), .ENCODER_MON_P(mon_p), .ENCODER_MON_N(mon_n),
		.DRIVE_STATE(st), .SPEED_CAP(spd_cap), .CURRENT_CAP_FWD(cur_fwd), .CURRENT_CAP_REV(cur_rev)
	);

	host_cmd_model host_u (.clk(clk), .fwd_p(fwd_p), .fwd_n(fwd_n), .rev_p(rev_p), .rev_n(rev_n));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge clk);
			k++;
			if (k > 50) begin
				n_fail++;
				conclude();
			end
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask

	// level change then wait past debounce
	task automatic set_pin(input int i, input logic v);
		@(posedge clk);
		pins[i] <= v;
		repeat (260) @(posedge clk);
	endtask

	task automatic edge_pin(input int i);
		set_pin(i, 1'b1);
		set_pin(i, 1'b0);
	endtask

	// ==========================================================
	// scenarios
	task automatic sc_reset;
		chk(32'(st), 32'h0, "drive state");
		chk(32'(spd_cap), 32'h0000ffff, "speed cap");
		chk(32'(mon_n), 32'h7, "monitor n");
		rdchk(servo_input_pkg::ADDR_POLARITY, 32'(servo_input_pkg::POLARITY_RESET), "polarity");
		rdchk(servo_input_pkg::ADDR_SPEED_LIM, 32'(servo_input_pkg::SPEED_LIM_RESET), "speed limit");
		bus(1'b1, 4'hf, 32'h1234_5678);
		rdchk(4'hf, 32'h0, "unmapped");
		@(posedge clk);
		enc <= 3'h5;
		repeat (6) @(posedge clk);
		chk(32'(mon_p), 32'h5, "monitor p");
		chk(32'(mon_n), 32'h2, "monitor n");
	endtask

	task automatic sc_enable_inhibit;
		set_pin(servo_input_pkg::IN_SERVO_ON, 1'b1);
		chk(32'(st.servo_power), 32'h1, "servo power");
		chk(32'({st.fwd_allowed, st.rev_allowed}), 32'h0, "both blocked");
		set_pin(servo_input_pkg::IN_FWD_INH, 1'b1);
		chk(32'({st.fwd_allowed, st.rev_allowed}), 32'h2, "fwd lifted");
		set_pin(servo_input_pkg::IN_REV_INH, 1'b1);
		chk(32'(st.rev_allowed), 32'h1, "rev lifted");
		set_pin(servo_input_pkg::IN_FWD_INH, 1'b0);
		chk(32'(st.fwd_allowed), 32'h0, "fwd blocked");
		bus(1'b1, servo_input_pkg::ADDR_POLARITY, 32'h2);
		repeat (260) @(posedge clk);
		chk(32'(st.fwd_allowed), 32'h1, "fwd inverted");
		bus(1'b1, servo_input_pkg::ADDR_POLARITY, 32'h0);
		set_pin(servo_input_pkg::IN_FWD_INH, 1'b1);
	endtask

	task automatic sc_limits;
		bus(1'b1, servo_input_pkg::ADDR_CUR_FWD, 32'h0123);
		bus(1'b1, servo_input_pkg::ADDR_CUR_REV, 32'h0321);
		set_pin(servo_input_pkg::IN_SPEED_LIM, 1'b1);
		set_pin(servo_input_pkg::IN_CUR_LIM, 1'b1);
		chk(32'(spd_cap), 32'(servo_input_pkg::SPEED_LIM_RESET), "speed cap");
		chk(32'({cur_fwd, cur_rev}), 32'h0123_0321, "current caps");
		chk(32'({st.speed_limited, st.current_limited}), 32'h3, "limit flags");
		set_pin(servo_input_pkg::IN_SPEED_LIM, 1'b0);
		set_pin(servo_input_pkg::IN_CUR_LIM, 1'b0);
		chk(32'(spd_cap), 32'h0000ffff, "speed cap off");
	endtask

	task automatic sc_formats;
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, servo_input_pkg::ADDR_PULSE_MODE, 32'(m));
			edge_pin(servo_input_pkg::IN_DEVIATION_CLEAR_IN);
			rdchk(servo_input_pkg::ADDR_DEVIATION, 32'h0, "dev cleared");
			host_u.send(2'(m), 1'b0, 2);
			rdchk(servo_input_pkg::ADDR_DEVIATION, (m == 2) ? 32'h8 : 32'h2, "dev fwd");
			host_u.send(2'(m), 1'b1, 1);
			rdchk(servo_input_pkg::ADDR_DEVIATION, (m == 2) ? 32'h4 : 32'h1, "dev rev");
		end
		bus(1'b1, servo_input_pkg::ADDR_PULSE_MODE, 32'h0);
		edge_pin(servo_input_pkg::IN_COMB_CLR);
		rdchk(servo_input_pkg::ADDR_DEVIATION, 32'h0, "dev comb");
		rdchk(servo_input_pkg::ADDR_FB_COUNT, 32'h0, "fb comb");
		rdchk(servo_input_pkg::ADDR_CMD_COUNT, 32'h0, "cmd comb");
		bus(1'b1, servo_input_pkg::ADDR_CONTROL, 32'h4);
		edge_pin(servo_input_pkg::IN_DEVIATION_CLEAR_IN);
		rdchk(servo_input_pkg::ADDR_CMD_COUNT, 32'h1, "cmd aligned");
		set_pin(servo_input_pkg::IN_SERVO_ON, 1'b0);
		host_u.send(2'h0, 1'b0, 3);
		rdchk(servo_input_pkg::ADDR_DEVIATION, 32'h0, "dev servo off");
		set_pin(servo_input_pkg::IN_SERVO_ON, 1'b1);
	endtask

	task automatic sc_overflow;
		bus(1'b1, servo_input_pkg::ADDR_OVF_LIMIT, 32'h3);
		host_u.send(2'h0, 1'b0, 5);
		chk(32'({st.alarm, st.servo_power}), 32'h2, "overflow");
		edge_pin(servo_input_pkg::IN_ALARM_CLR);
		chk(32'(st.alarm), 32'h1, "clear too early");
		edge_pin(servo_input_pkg::IN_DEVIATION_CLEAR_IN);
		edge_pin(servo_input_pkg::IN_ALARM_CLR);
		chk(32'({st.alarm, st.servo_power}), 32'h1, "alarm cleared");
		host_u.send(2'h0, 1'b0, 5);
		set_pin(servo_input_pkg::IN_COMB_CLR, 1'b1);
		chk(32'(st.alarm), 32'h0, "comb cleared");
		rdchk(servo_input_pkg::ADDR_DEVIATION, 32'h0, "dev zero");
		host_u.send(2'h0, 1'b0, 5);
		chk(32'(st.alarm), 32'h1, "level no clear");
		set_pin(servo_input_pkg::IN_COMB_CLR, 1'b0);
		edge_pin(servo_input_pkg::IN_COMB_CLR);
		bus(1'b1, servo_input_pkg::ADDR_CONTROL, 32'h2);
		set_pin(servo_input_pkg::IN_CUR_LIM, 1'b1);
		host_u.send(2'h0, 1'b0, 2);
		chk(32'({st.alarm, st.servo_power}), 32'h2, "stall overflow");
		set_pin(servo_input_pkg::IN_CUR_LIM, 1'b0);
	endtask

	task automatic sc_fatal;
		bus(1'b1, servo_input_pkg::ADDR_CONTROL, 32'h1);
		edge_pin(servo_input_pkg::IN_ALARM_CLR);
		edge_pin(servo_input_pkg::IN_COMB_CLR);
		chk(32'({st.alarm, st.fatal, st.servo_power}), 32'h2, "fatal kept");
	endtask

	initial begin
		arst_n = 1'b0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		pins = 8'h00;
		enc = 3'h0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		sc_reset();
		sc_enable_inhibit();
		sc_limits();
		sc_formats();
		sc_overflow();
		sc_fatal();
		conclude();
	end
endmodule
